// File: amp_model.sv
module amp_model (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic drive_one,
  input  wire logic lie,
  input  wire logic decel_stop_in,
  input  wire logic stroke_end_pos,
  input  wire logic stroke_end_neg,
  input  wire logic alarm_reset_cmd,
  input  wire logic servo_on_cmd,
  input  wire logic ctrl_supply_ok,
  input  wire logic main_below_uv,
  input  wire logic main_below_uv80,
  output logic      state_fb,
  output logic      forced_decel,
  output logic      dyn_brake,
  output logic      undervoltage_alarm,
  output logic      servo_off
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lag;

  // Feedback closed while driving, open in shut-off; lie forces a wrong report
  always_ff @(posedge clk_sys) begin
    lag      <= drive_one;
    state_fb <= lag ^ lie;
  end

  // Forced stop deceleration needs the control supply; without it only the brake acts
  always_ff @(posedge clk_sys) begin
    servo_off    <= !servo_on_cmd;
    forced_decel <= ctrl_supply_ok && (!decel_stop_in
      || ((!stroke_end_pos || !stroke_end_neg) && !alarm_reset_cmd && servo_on_cmd)
      || (main_below_uv && !main_below_uv80));
    dyn_brake    <= !ctrl_supply_ok || main_below_uv80;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || alarm_reset_cmd) begin
      undervoltage_alarm <= 1'b0;
    end else if (main_below_uv) begin
      undervoltage_alarm <= 1'b1;
    end
  end
endmodule

// File: contact_filter.sv
module contact_filter #(
  parameter logic [shutoff_pkg::FILT_W-1:0] FILT_CYC = shutoff_pkg::FILT_W'(shutoff_pkg::TEST_PULSE_CYC)
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic contact_raw,
  output logic      contact_closed
);

  logic                            sync_one;
  logic                            sync_two;
  logic [shutoff_pkg::FILT_W-1:0]  hold_cnt;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync_one <= 1'b0;
      sync_two <= 1'b0;
    end else begin
      sync_one <= contact_raw;
      sync_two <= sync_one;
    end
  end

  // A change is taken only once it has held for FILT_CYC cycles, so test
  // pulses are ignored; opening still reaches the output well inside 10 ms.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      contact_closed <= 1'b0;
      hold_cnt       <= '0;
    end else if (sync_two == contact_closed) begin
      hold_cnt <= '0;
    end else if (hold_cnt >= FILT_CYC - 1'b1) begin
      contact_closed <= sync_two;
      hold_cnt       <= '0;
    end else begin
      hold_cnt <= hold_cnt + 1'b1;
    end
  end

endmodule

// File: dual_axis_safe_shutoff_logic.sv
// How it works
// - Both drive shut-off channels of an axis always carry the same state.
// - Drive shut-off channel open when axis shut off, closed when released.
// - Open shutdown input commands shut-off; closed means released for driving.
// - Both general shut-off outputs of an axis mirror the axis shut-off state.
// - General shut-off output open when shut off, closed when driving.
// - Each axis has its own dedicated switching output port.
// - Latched shut-off is left only when release goes from connected to opened.
// - Axis A shut-off delay selectable: 0, 1.4, 2.8, 5.6, 9.8, 30.8 s.
// - With zero delay, outputs turn off within 10 ms of input turning off.
module dual_axis_safe_shutoff_logic #(
  parameter logic [shutoff_pkg::FILT_W-1:0] FILT_CYC      = shutoff_pkg::FILT_W'(shutoff_pkg::TEST_PULSE_CYC),
  parameter logic [shutoff_pkg::FB_W-1:0]   FB_CHECK_CYC  = shutoff_pkg::FB_W'(shutoff_pkg::RESP_MAX_CYC),
  parameter logic [shutoff_pkg::DLY_W-1:0]  DLY_1400_CYC  = shutoff_pkg::DLY_W'(shutoff_pkg::DLY_1400_CYC),
  parameter logic [shutoff_pkg::DLY_W-1:0]  DLY_2800_CYC  = shutoff_pkg::DLY_W'(shutoff_pkg::DLY_2800_CYC),
  parameter logic [shutoff_pkg::DLY_W-1:0]  DLY_5600_CYC  = shutoff_pkg::DLY_W'(shutoff_pkg::DLY_5600_CYC),
  parameter logic [shutoff_pkg::DLY_W-1:0]  DLY_9800_CYC  = shutoff_pkg::DLY_W'(shutoff_pkg::DLY_9800_CYC),
  parameter logic [shutoff_pkg::DLY_W-1:0]  DLY_30800_CYC = shutoff_pkg::DLY_W'(shutoff_pkg::DLY_30800_CYC)
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       axis_a_shutdown_in_one,
  input  wire logic       axis_a_shutdown_in_two,
  input  wire logic       axis_b_shutdown_in_one,
  input  wire logic       axis_b_shutdown_in_two,
  input  wire logic       axis_a_release_in,
  input  wire logic       axis_b_release_in,
  input  wire logic [2:0] axis_a_delay_sel,
  input  wire logic [2:0] axis_b_delay_sel,
  input  wire logic       axis_a_state_fb_one,
  input  wire logic       axis_b_state_fb_one,
  output logic            axis_a_drive_off_one,
  output logic            axis_a_drive_off_two,
  output logic            axis_b_drive_off_one,
  output logic            axis_b_drive_off_two,
  output logic            axis_a_gen_off_one,
  output logic            axis_a_gen_off_two,
  output logic            axis_b_gen_off_one,
  output logic            axis_b_gen_off_two,
  output logic            axis_a_switching,
  output logic            axis_b_switching,
  output logic            axis_a_fb_fault,
  output logic            axis_b_fb_fault
);

  localparam int N = shutoff_pkg::NUM_AXES;

  logic [N-1:0] sd_one_raw;
  logic [N-1:0] sd_two_raw;
  logic [N-1:0] rel_raw;
  logic [N-1:0] fb_raw;
  logic [N-1:0] sd_one;
  logic [N-1:0] sd_two;
  logic [N-1:0] rel;
  logic [N-1:0] fb;
  logic [N-1:0] rel_prev;
  logic [N-1:0] drive_one;
  logic [N-1:0] drive_two;
  logic [N-1:0] gen_one;
  logic [N-1:0] gen_two;
  logic [N-1:0] switching;
  logic [N-1:0] fb_fault;
  logic [2:0]   sel_raw   [N];
  logic [2:0]   sel_meta  [N];
  logic [2:0]   sel       [N];
  logic [shutoff_pkg::DLY_W-1:0] dly_cnt [N];
  logic [shutoff_pkg::FB_W-1:0]  fb_cnt  [N];
  shutoff_pkg::axis_state_e      state   [N];

  assign sd_one_raw = {axis_b_shutdown_in_one, axis_a_shutdown_in_one};
  assign sd_two_raw = {axis_b_shutdown_in_two, axis_a_shutdown_in_two};
  assign rel_raw    = {axis_b_release_in, axis_a_release_in};
  assign fb_raw     = {axis_b_state_fb_one, axis_a_state_fb_one};
  assign sel_raw[shutoff_pkg::AXIS_A] = axis_a_delay_sel;
  assign sel_raw[shutoff_pkg::AXIS_B] = axis_b_delay_sel;

  // Unknown switch codes pick zero delay: the safe side is stopping sooner.
  function automatic logic [shutoff_pkg::DLY_W-1:0] delay_cycles(input int axis, input logic [2:0] code);
    logic [shutoff_pkg::DLY_W-1:0] d;
    d = '0;
    if (axis == shutoff_pkg::AXIS_A) begin
      case (code)
        shutoff_pkg::SEL_A_1S4:  d = DLY_1400_CYC;
        shutoff_pkg::SEL_A_2S8:  d = DLY_2800_CYC;
        shutoff_pkg::SEL_A_5S6:  d = DLY_5600_CYC;
        shutoff_pkg::SEL_A_9S8:  d = DLY_9800_CYC;
        shutoff_pkg::SEL_A_30S8: d = DLY_30800_CYC;
        default:                 d = '0;
      endcase
    end else begin
      case (code)
        shutoff_pkg::SEL_B_1S4:  d = DLY_1400_CYC;
        shutoff_pkg::SEL_B_2S8:  d = DLY_2800_CYC;
        shutoff_pkg::SEL_B_9S8:  d = DLY_9800_CYC;
        shutoff_pkg::SEL_B_30S8: d = DLY_30800_CYC;
        default:                 d = '0;
      endcase
    end
    return d;
  endfunction

  function automatic logic passes_current(input shutoff_pkg::axis_state_e s);
    return (s == shutoff_pkg::ST_RUN) || (s == shutoff_pkg::ST_DELAY);
  endfunction

  for (genvar i = 0; i < N; i++) begin : g_axis
    contact_filter #(.FILT_CYC(FILT_CYC)) u_sd_one (
      .clk_sys        (clk_sys),
      .sys_rst        (sys_rst),
      .contact_raw    (sd_one_raw[i]),
      .contact_closed (sd_one[i])
    );
    contact_filter #(.FILT_CYC(FILT_CYC)) u_sd_two (
      .clk_sys        (clk_sys),
      .sys_rst        (sys_rst),
      .contact_raw    (sd_two_raw[i]),
      .contact_closed (sd_two[i])
    );
    contact_filter #(.FILT_CYC(FILT_CYC)) u_rel (
      .clk_sys        (clk_sys),
      .sys_rst        (sys_rst),
      .contact_raw    (rel_raw[i]),
      .contact_closed (rel[i])
    );
    contact_filter #(.FILT_CYC(FILT_CYC)) u_fb (
      .clk_sys        (clk_sys),
      .sys_rst        (sys_rst),
      .contact_raw    (fb_raw[i]),
      .contact_closed (fb[i])
    );

    // Delay switch is static in use; a per-bit synchroniser is enough
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        sel_meta[i] <= 3'h0;
        sel[i]      <= 3'h0;
      end else begin
        sel_meta[i] <= sel_raw[i];
        sel[i]      <= sel_meta[i];
      end
    end

    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        rel_prev[i] <= 1'b0;
      end else begin
        rel_prev[i] <= rel[i];
      end
    end

    // Power-up lands in the latched shut-off state; a release is required.
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        state[i]   <= shutoff_pkg::ST_OFF;
        dly_cnt[i] <= '0;
      end else begin
        case (state[i])
          shutoff_pkg::ST_RUN: begin
            if (!(sd_one[i] && sd_two[i])) begin
              if (delay_cycles(i, sel[i]) == '0) begin
                state[i] <= shutoff_pkg::ST_OFF;
              end else begin
                dly_cnt[i] <= delay_cycles(i, sel[i]);
                state[i]   <= shutoff_pkg::ST_DELAY;
              end
            end
          end
          shutoff_pkg::ST_DELAY: begin
            // Once started the delayed stop runs out even if inputs close again
            if (dly_cnt[i] <= 1) begin
              state[i] <= shutoff_pkg::ST_OFF;
            end else begin
              dly_cnt[i] <= dly_cnt[i] - 1'b1;
            end
          end
          shutoff_pkg::ST_OFF: begin
            if (rel[i] && sd_one[i] && sd_two[i]) begin
              state[i] <= shutoff_pkg::ST_ARMED;
            end
          end
          shutoff_pkg::ST_ARMED: begin
            if (!(sd_one[i] && sd_two[i])) begin
              state[i] <= shutoff_pkg::ST_OFF;
            end else if (rel_prev[i] && !rel[i]) begin
              state[i] <= shutoff_pkg::ST_RUN;
            end
          end
          default: begin
            state[i] <= shutoff_pkg::ST_OFF;
          end
        endcase
      end
    end

    // All five contacts of an axis come from one decode of the state, so they never differ
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        drive_one[i] <= 1'b0;
        drive_two[i] <= 1'b0;
        gen_one[i]   <= 1'b0;
        gen_two[i]   <= 1'b0;
        switching[i] <= 1'b0;
      end else begin
        drive_one[i] <= passes_current(state[i]);
        drive_two[i] <= passes_current(state[i]);
        gen_one[i]   <= passes_current(state[i]);
        gen_two[i]   <= passes_current(state[i]);
        switching[i] <= passes_current(state[i]);
      end
    end

    // Amplifier feedback must follow our outputs within the response time
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        fb_cnt[i]   <= '0;
        fb_fault[i] <= 1'b0;
      end else if (fb[i] == drive_one[i]) begin
        fb_cnt[i]   <= '0;
        fb_fault[i] <= 1'b0;
      end else if (fb_cnt[i] >= FB_CHECK_CYC - 1'b1) begin
        fb_fault[i] <= 1'b1;
      end else begin
        fb_cnt[i] <= fb_cnt[i] + 1'b1;
      end
    end
  end

  assign axis_a_drive_off_one = drive_one[shutoff_pkg::AXIS_A];
  assign axis_a_drive_off_two = drive_two[shutoff_pkg::AXIS_A];
  assign axis_b_drive_off_one = drive_one[shutoff_pkg::AXIS_B];
  assign axis_b_drive_off_two = drive_two[shutoff_pkg::AXIS_B];
  assign axis_a_gen_off_one   = gen_one[shutoff_pkg::AXIS_A];
  assign axis_a_gen_off_two   = gen_two[shutoff_pkg::AXIS_A];
  assign axis_b_gen_off_one   = gen_one[shutoff_pkg::AXIS_B];
  assign axis_b_gen_off_two   = gen_two[shutoff_pkg::AXIS_B];
  assign axis_a_switching     = switching[shutoff_pkg::AXIS_A];
  assign axis_b_switching     = switching[shutoff_pkg::AXIS_B];
  assign axis_a_fb_fault      = fb_fault[shutoff_pkg::AXIS_A];
  assign axis_b_fb_fault      = fb_fault[shutoff_pkg::AXIS_B];

endmodule

// File: shutoff_checker.sv
module shutoff_checker (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       axis_a_shutdown_in_one,
  input wire logic       axis_a_shutdown_in_two,
  input wire logic       axis_a_release_in,
  input wire logic [2:0] axis_a_delay_sel,
  input wire logic       axis_a_state_fb_one,
  input wire logic       axis_a_drive_off_one,
  input wire logic       axis_a_drive_off_two,
  input wire logic       axis_b_drive_off_one,
  input wire logic       axis_b_drive_off_two,
  input wire logic       axis_a_gen_off_one,
  input wire logic       axis_a_gen_off_two,
  input wire logic       axis_b_gen_off_one,
  input wire logic       axis_b_gen_off_two,
  input wire logic       axis_a_switching,
  input wire logic       axis_b_switching,
  input wire logic       axis_a_fb_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] rel_age;
  logic [5:0] fb_cnt;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Cycles since the release contact last opened, saturating
  always_ff @(posedge clk_sys) begin
    if (sys_rst) rel_age <= 6'h3f;
    else if ($fell(axis_a_release_in)) rel_age <= 6'h0;
    else if (rel_age != 6'h3f) rel_age <= rel_age + 6'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || axis_a_state_fb_one == axis_a_drive_off_one) fb_cnt <= 6'h0;
    else if (fb_cnt != 6'h3f) fb_cnt <= fb_cnt + 6'h1;
  end

  sequence stop_start(sel);
    $fell(axis_a_shutdown_in_one && axis_a_shutdown_in_two) && axis_a_drive_off_one && axis_a_delay_sel == sel;
  endsequence
  sequence open_held;
    (!(axis_a_shutdown_in_one && axis_a_shutdown_in_two)) [*8];
  endsequence

  a_drive_pair_equal: assert property (axis_a_drive_off_one == axis_a_drive_off_two &&
    axis_b_drive_off_one == axis_b_drive_off_two) else $error("drive channels differ");
  a_gen_off_mirror: assert property (axis_a_gen_off_one == axis_a_drive_off_one &&
    axis_a_gen_off_two == axis_a_drive_off_one && axis_b_gen_off_one == axis_b_drive_off_one &&
    axis_b_gen_off_two == axis_b_drive_off_one) else $error("general outputs differ from drive");
  a_switch_port_mirror: assert property (axis_a_switching == axis_a_drive_off_one &&
    axis_b_switching == axis_b_drive_off_one) else $error("switching output differs");
  a_reset_all_open: assert property (@(posedge clk_sys) disable iff (1'b0)
    sys_rst |=> !axis_a_drive_off_one && !axis_b_drive_off_one) else $error("output closed in reset");
  a_zero_delay_stop: assert property (stop_start(3'h0) ##1 open_held |-> ##[0:6] !axis_a_drive_off_one)
    else $error("zero delay stop too slow");
  a_delay_holds_off: assert property (stop_start(3'h1) ##1 open_held
    |-> axis_a_drive_off_one ##[1:14] !axis_a_drive_off_one) else $error("delayed stop timing wrong");
  a_release_on_edge: assert property ($rose(axis_a_drive_off_one) |-> rel_age <= 6'he)
    else $error("drive without release edge");
  a_fb_fault_rises: assert property (fb_cnt >= 6'h28 |-> axis_a_fb_fault) else $error("feedback fault missing");
endmodule

bind dual_axis_safe_shutoff_logic shutoff_checker shutoff_checker_inst (.*);

// File: shutoff_pkg.sv
package shutoff_pkg;

  // Clock rate expressed as cycles per unit of time (250 MHz)
  localparam int     CLK_CYC_PER_MS  = 250_000;
  localparam int     CLK_CYC_PER_US  = 250;

  localparam int     NUM_AXES        = 2;
  localparam int     AXIS_A          = 0;
  localparam int     AXIS_B          = 1;

  // Longest off pulse of a controller contact test that must be ignored
  localparam int     TEST_PULSE_US   = 1000;
  localparam longint TEST_PULSE_CYC  = longint'(TEST_PULSE_US) * CLK_CYC_PER_US;

  // Response bound with zero delay; also used as feedback settle time
  localparam int     RESP_MAX_MS     = 10;
  localparam longint RESP_MAX_CYC    = longint'(RESP_MAX_MS) * CLK_CYC_PER_MS;

  // Selectable shut-off delays
  localparam int     DLY_1400_MS     = 1400;
  localparam int     DLY_2800_MS     = 2800;
  localparam int     DLY_5600_MS     = 5600;
  localparam int     DLY_9800_MS     = 9800;
  localparam int     DLY_30800_MS    = 30800;
  localparam longint DLY_1400_CYC    = longint'(DLY_1400_MS) * CLK_CYC_PER_MS;
  localparam longint DLY_2800_CYC    = longint'(DLY_2800_MS) * CLK_CYC_PER_MS;
  localparam longint DLY_5600_CYC    = longint'(DLY_5600_MS) * CLK_CYC_PER_MS;
  localparam longint DLY_9800_CYC    = longint'(DLY_9800_MS) * CLK_CYC_PER_MS;
  localparam longint DLY_30800_CYC   = longint'(DLY_30800_MS) * CLK_CYC_PER_MS;

  // Counter widths and delay switch code width
  localparam int     DLY_W           = 33;
  localparam int     FILT_W          = 18;
  localparam int     FB_W            = 22;
  localparam int     SEL_W           = 3;

  // Delay switch codes, axis A
  localparam logic [2:0] SEL_A_0S    = 3'h0;
  localparam logic [2:0] SEL_A_1S4   = 3'h1;
  localparam logic [2:0] SEL_A_2S8   = 3'h2;
  localparam logic [2:0] SEL_A_5S6   = 3'h3;
  localparam logic [2:0] SEL_A_9S8   = 3'h4;
  localparam logic [2:0] SEL_A_30S8  = 3'h5;
  // Delay switch codes, axis B (no 5.6 s choice)
  localparam logic [2:0] SEL_B_0S    = 3'h0;
  localparam logic [2:0] SEL_B_1S4   = 3'h1;
  localparam logic [2:0] SEL_B_2S8   = 3'h2;
  localparam logic [2:0] SEL_B_9S8   = 3'h3;
  localparam logic [2:0] SEL_B_30S8  = 3'h4;

  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_DELAY = 4'h2,
    ST_OFF   = 4'h4,
    ST_ARMED = 4'h8
  } axis_state_e;

endpackage

// File: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 10;
  logic clk_sys, sys_rst, lie_a;
  logic axis_a_shutdown_in_one, axis_a_shutdown_in_two, axis_b_shutdown_in_one, axis_b_shutdown_in_two;
  logic axis_a_release_in, axis_b_release_in, axis_a_state_fb_one, axis_b_state_fb_one;
  logic [2:0] axis_a_delay_sel, axis_b_delay_sel;
  logic axis_a_drive_off_one, axis_a_drive_off_two, axis_b_drive_off_one, axis_b_drive_off_two;
  logic axis_a_gen_off_one, axis_a_gen_off_two, axis_b_gen_off_one, axis_b_gen_off_two;
  logic axis_a_switching, axis_b_switching, axis_a_fb_fault, axis_b_fb_fault;
  logic lie_b, decel_stop_in, stroke_end_pos, stroke_end_neg, alarm_reset_cmd, servo_on_cmd, ctrl_supply_ok;
  logic main_below_uv, main_below_uv80, forced_decel, dyn_brake, undervoltage_alarm, servo_off;
  int   n_fail, cmp_count, lat0, lat;

  dual_axis_safe_shutoff_logic #(
    .FILT_CYC      (18'h4),
    .FB_CHECK_CYC  (22'h14),
    .DLY_1400_CYC  (shutoff_pkg::DLY_W'(STEP)),
    .DLY_2800_CYC  (shutoff_pkg::DLY_W'(STEP * 2)),
    .DLY_5600_CYC  (shutoff_pkg::DLY_W'(STEP * 3)),
    .DLY_9800_CYC  (shutoff_pkg::DLY_W'(STEP * 4)),
    .DLY_30800_CYC (shutoff_pkg::DLY_W'(STEP * 5))
  ) dual_axis_safe_shutoff_logic_inst (.*);
  amp_model amp_a_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .drive_one(axis_a_drive_off_one), .lie(lie_a),
    .decel_stop_in(decel_stop_in), .stroke_end_pos(stroke_end_pos), .stroke_end_neg(stroke_end_neg),
    .alarm_reset_cmd(alarm_reset_cmd), .servo_on_cmd(servo_on_cmd), .ctrl_supply_ok(ctrl_supply_ok),
    .main_below_uv(main_below_uv), .main_below_uv80(main_below_uv80), .state_fb(axis_a_state_fb_one),
    .forced_decel(forced_decel), .dyn_brake(dyn_brake), .undervoltage_alarm(undervoltage_alarm),
    .servo_off(servo_off));
  amp_model amp_b_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .drive_one(axis_b_drive_off_one), .lie(lie_b),
    .decel_stop_in(1'b1), .stroke_end_pos(1'b1), .stroke_end_neg(1'b1), .alarm_reset_cmd(1'b0),
    .servo_on_cmd(1'b1), .ctrl_supply_ok(1'b1), .main_below_uv(1'b0), .main_below_uv80(1'b0),
    .state_fb(axis_b_state_fb_one), .forced_decel(), .dyn_brake(), .undervoltage_alarm(), .servo_off());

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(string name, logic [4:0] seen, logic [4:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic [4:0] outs_a();
    return {axis_a_switching, axis_a_gen_off_two, axis_a_gen_off_one, axis_a_drive_off_two, axis_a_drive_off_one};
  endfunction
  function automatic logic [4:0] outs_b();
    return {axis_b_switching, axis_b_gen_off_two, axis_b_gen_off_one, axis_b_drive_off_two, axis_b_drive_off_one};
  endfunction
  function automatic logic [4:0] amp_outs();
    return {1'b0, servo_off, undervoltage_alarm, dyn_brake, forced_decel};
  endfunction

  task automatic report_and_stop();
    $display("n_fail=%0d cmp_count=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Close both channels, connect then open release
  task automatic release_both();
    {axis_a_shutdown_in_one, axis_a_shutdown_in_two, axis_b_shutdown_in_one, axis_b_shutdown_in_two} = 4'hf;
    tick(12);
    {axis_a_release_in, axis_b_release_in} = 2'h3;
    tick(20);
    check("armed_a", outs_a(), 5'h00);
    {axis_a_release_in, axis_b_release_in} = 2'h0;
    tick(14);
  endtask

  task automatic wait_fall_a();
    lat = 0;
    while (axis_a_drive_off_one !== 1'b0 && lat < 200) begin
      tick(1);
      lat++;
    end
    if (lat >= 200) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  task automatic t_reset_and_release();
    check("reset_a", outs_a(), 5'h00);
    check("reset_b", outs_b(), 5'h00);
    release_both();
    check("run_a", outs_a(), 5'h1f);
    check("run_b", outs_b(), 5'h1f);
  endtask

  task automatic t_one_channel();
    axis_a_shutdown_in_two = 1'b0;
    wait_fall_a();
    lat0 = lat;
    check("fast_stop", 5'(lat0 <= 16), 5'h1);
    check("stop_outs_a", outs_a(), 5'h00);
    check("b_untouched", outs_b(), 5'h1f);
    // Stay open long enough for the checker's zero-delay window to see it
    tick(2);
    axis_a_shutdown_in_two = 1'b1;
    tick(20);
    check("latched_a", outs_a(), 5'h00);
  endtask

  task automatic t_refused_release();
    axis_a_shutdown_in_one = 1'b0;
    axis_a_release_in = 1'b1;
    tick(12);
    axis_a_release_in = 1'b0;
    tick(14);
    check("open_refuse", outs_a(), 5'h00);
    axis_a_shutdown_in_one = 1'b1;
  endtask

  task automatic t_fb_fault();
    lie_a = 1'b1;
    tick(60);
    check("fb_fault_on", 5'(axis_a_fb_fault), 5'h1);
    check("fb_b_quiet", 5'(axis_b_fb_fault), 5'h0);
    {lie_a, lie_b} = 2'h1;
    tick(60);
    check("fb_fault_off", 5'(axis_a_fb_fault), 5'h0);
    check("fb_fault_on_b", 5'(axis_b_fb_fault), 5'h1);
    lie_b = 1'b0;
    tick(20);
    check("fb_fault_off_b", 5'(axis_b_fb_fault), 5'h0);
  endtask

  task automatic t_delays();
    for (int k = 1; k <= 5; k++) begin
      axis_a_delay_sel = 3'(k);
      release_both();
      {axis_a_shutdown_in_one, axis_a_shutdown_in_two} = 2'h0;
      wait_fall_a();
      check("delay_len", 5'(lat >= lat0 + STEP * k - 1 && lat <= lat0 + STEP * k + 2), 5'h1);
    end
    axis_a_delay_sel = 3'h0;
    // Axis B has its own switch coding; one delayed stop proves it is decoded
    axis_b_delay_sel = shutoff_pkg::SEL_B_9S8;
    release_both();
    {axis_b_shutdown_in_one, axis_b_shutdown_in_two} = 2'h0;
    tick(lat0 + STEP * 4 - 2);
    check("delay_b_hold", outs_b(), 5'h1f);
    tick(4);
    check("delay_b_off", outs_b(), 5'h00);
    axis_b_delay_sel = 3'h0;
  endtask

  // Amplifier model reactions, coded as {servo_off, alarm, brake, decel}
  task automatic t_amp_model();
    tick(2);
    check("amp_idle", amp_outs(), 5'h00);
    decel_stop_in = 1'b0;
    tick(2);
    check("amp_decel_stop", amp_outs(), 5'h01);
    ctrl_supply_ok = 1'b0;
    tick(2);
    check("amp_ctrl_loss", amp_outs(), 5'h02);
    {decel_stop_in, ctrl_supply_ok, stroke_end_pos} = 3'h6;
    tick(2);
    check("amp_stroke_end", amp_outs(), 5'h01);
    alarm_reset_cmd = 1'b1;
    tick(2);
    check("amp_stroke_reset", amp_outs(), 5'h00);
    {alarm_reset_cmd, stroke_end_pos, main_below_uv} = 3'h3;
    tick(2);
    check("amp_main_uv", amp_outs(), 5'h05);
    main_below_uv80 = 1'b1;
    tick(2);
    check("amp_main_uv80", amp_outs(), 5'h06);
    {main_below_uv, main_below_uv80, alarm_reset_cmd} = 3'h1;
    tick(2);
    check("amp_alarm_clear", amp_outs(), 5'h00);
    {alarm_reset_cmd, servo_on_cmd} = 2'h0;
    tick(2);
    check("amp_servo_off", amp_outs(), 5'h08);
    servo_on_cmd = 1'b1;
  endtask

  initial begin
    {axis_a_shutdown_in_one, axis_a_shutdown_in_two, axis_b_shutdown_in_one, axis_b_shutdown_in_two} = 4'h0;
    {axis_a_release_in, axis_b_release_in, lie_a} = 3'h0;
    {decel_stop_in, stroke_end_pos, stroke_end_neg, alarm_reset_cmd, servo_on_cmd} = 5'h1d;
    {ctrl_supply_ok, main_below_uv, main_below_uv80, lie_b} = 4'h8;
    axis_a_delay_sel = 3'h0;
    axis_b_delay_sel = 3'h0;
    n_fail = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    tick(10);
    sys_rst = 1'b0;
    tick(2);
    t_reset_and_release();
    t_one_channel();
    t_refused_release();
    t_fb_fault();
    t_delays();
    t_amp_model();
    report_and_stop();
  end
endmodule
